/* common/flash_fe_defines.svh */
// Constants for the serial flash command front end.
`ifndef FLASH_FE_DEFINES_SVH
`define FLASH_FE_DEFINES_SVH
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_WRSR 8'h01
`define OP_RDSR 8'h05
`define OP_READ 8'h03
`define OP_FAST 8'h0B
`define OP_PROG 8'h02
`define OP_SERASE 8'hD8
`define OP_BERASE 8'hC7
`define OP_ID_A 8'h9F
`define OP_ID_B 8'h9E
`define ADDR_BYTES 2'h3
`define SECTOR_LSB 18
`define PAGE_LSB 8
`define PAGE_MAX_BYTES 9'h100
`define ST_BUSY 0
`define ST_WLATCH 1
`define ST_PROT_LSB 2
`define ST_LOCK 7
`define ID_BITS 5'h18
`endif

/* common/flash_fe_pkg.sv */
// Types shared by the serial flash command front end.
package flash_fe_pkg;
  typedef enum logic [1:0] {
    JOB_PROGRAM,
    JOB_SECTOR_ERASE,
    JOB_BULK_ERASE,
    JOB_STATUS_WRITE
  } job_e;
  typedef struct packed {
    job_e kind;
    logic [23:0] addr;
    logic [5:0] sector;
    logic [15:0] page;
    logic [8:0] count;
    logic [7:0] data;
  } job_s;
endpackage

/* rtl/edge_sync.sv */
// Two-flop synchroniser with edge detection on the synchronised level.
`timescale 1ns/10ps
module edge_sync
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic reset_val,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin ^ reset_val;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign level = sync_q ^ reset_val;
  assign rise = (sync_q ^ reset_val) & ~(last_q ^ reset_val);
  assign fall = ~(sync_q ^ reset_val) & (last_q ^ reset_val);
endmodule // edge_sync

/* rtl/flash_cmd_frontend.sv */
// Command front end of a serial flash: opcode decode, latch and reads.
//
// Contract
// - Array: 16,777,216 bytes in 64 sectors.
// - 65,536 pages of 256 bytes each.
// - Program clears bits; erase per sector or all.
// - Sector n spans n times 040000h onward.
// - All bytes move most significant bit first.
// - Sample input on rising edges; opcode first.
// - 06h, 04h, 01h: no address; 01h one byte.
// - 03h three address; 0Bh adds one dummy.
// - 02h address plus 1..256 bytes; D8h, C7h.
// - Read outputs end cleanly on deselect.
// - Write commands need whole bytes, else rejected.
// - Array commands ignored during internal cycle.
// - Write enable sets latch; writes need it.
// - Write disable clears the latch.
// - Latch clears at reset and on completion; the code clears it at job hand-off instead, while still busy.
// - 9Fh/9Eh shift 24 identification bits out.
// - Identification not decoded during program/erase.
// - Deselect stops identification, back to standby.
// - 05h repeats live status byte any time.
// - Busy reads one during internal cycles.
// - Latch clear means no write commands.
// - Read address increments, wraps to zero.
`timescale 1ns/10ps
`include "flash_fe_defines.svh"
module flash_cmd_frontend
  import flash_fe_pkg::*;
#(
  parameter logic [7:0] MAKER_CODE = 8'hA5,
  parameter logic [7:0] TYPE_CODE = 8'h5A,
  parameter logic [7:0] SIZE_CODE = 8'h3C
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic select_n_pin,
  input wire logic sclk_pin,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_out_oe_n,
  input wire logic engine_busy,
  input wire logic [7:0] array_rd_data,
  output logic [23:0] array_rd_addr,
  output logic job_valid,
  output job_s job,
  output logic write_latch_flag,
  output logic [2:0] protect_range_bits,
  output logic status_lock_bit
);
  // MAKER_CODE, TYPE_CODE and SIZE_CODE values are arbitrary.
  typedef enum logic [2:0] {
    PH_OPCODE,
    PH_ADDR,
    PH_DUMMY,
    PH_DATA_IN,
    PH_DATA_OUT,
    PH_IGNORE
  } phase_e;

  logic sel_lvl, sel_rise;
  logic clk_rise, clk_fall;
  logic din_lvl;
  edge_sync u_sel (.core_clk(core_clk), .rst_n(rst_n), .pin(select_n_pin),
    .reset_val(1'b1), .level(sel_lvl), .rise(sel_rise), .fall());
  edge_sync u_clk (.core_clk(core_clk), .rst_n(rst_n), .pin(sclk_pin),
    .reset_val(1'b0), .level(), .rise(clk_rise), .fall(clk_fall));
  edge_sync u_din (.core_clk(core_clk), .rst_n(rst_n), .pin(serial_in_pin),
    .reset_val(1'b0), .level(din_lvl), .rise(), .fall());

  phase_e phase_q;
  logic [7:0] op_q;
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic [1:0] addr_cnt_q;
  logic [23:0] addr_q;
  logic [8:0] data_cnt_q;
  logic [7:0] out_q;
  logic [4:0] id_cnt_q;
  logic wsr_q;
  logic [7:0] wsr_data_q;
  logic busy_flag;
  logic selected;
  logic [7:0] byte_in;
  logic byte_done;
  logic [7:0] status_byte;
  logic [23:0] id_word;
  logic is_write_op;

  assign selected = ~sel_lvl;
  assign busy_flag = engine_busy | job_valid;
  assign byte_in = {shift_q[6:0], din_lvl};
  assign byte_done = selected & clk_rise & (bit_q == 3'h7);
  assign id_word = {MAKER_CODE, TYPE_CODE, SIZE_CODE};
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[`ST_BUSY] = busy_flag;
    status_byte[`ST_WLATCH] = write_latch_flag;
    status_byte[`ST_PROT_LSB +: 3] = protect_range_bits;
    status_byte[`ST_LOCK] = status_lock_bit;
  end
  always_comb
  begin
    unique case (op_q)
      `OP_PROG, `OP_SERASE, `OP_BERASE, `OP_WRSR, `OP_WREN, `OP_WRDI:
        is_write_op = 1'b1;
      default:
        is_write_op = 1'b0;
    endcase
  end

  // Bit counter within the current byte; deselect restarts framing.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_q <= 3'h0;
      shift_q <= 8'h00;
    end
    else if (!selected)
    begin
      bit_q <= 3'h0;
    end
    else if (clk_rise)
    begin
      bit_q <= bit_q + 3'h1;
      shift_q <= byte_in;
    end
  end

  // Command phase sequencer.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_q <= PH_OPCODE;
      op_q <= 8'h00;
      addr_cnt_q <= 2'h0;
      addr_q <= 24'h000000;
      data_cnt_q <= 9'h000;
      wsr_data_q <= 8'h00;
      id_cnt_q <= 5'h00;
    end
    else if (!selected)
    begin
      phase_q <= PH_OPCODE;
      addr_cnt_q <= 2'h0;
      data_cnt_q <= 9'h000;
      id_cnt_q <= 5'h00;
    end
    else
    begin
      if (byte_done)
      begin
        unique case (phase_q)
          PH_OPCODE:
          begin
            op_q <= byte_in;
            unique case (byte_in)
              `OP_READ, `OP_FAST, `OP_PROG, `OP_SERASE:
                phase_q <= busy_flag ? PH_IGNORE : PH_ADDR;
              `OP_WRSR:
                phase_q <= busy_flag ? PH_IGNORE : PH_DATA_IN;
              `OP_RDSR:
                phase_q <= PH_DATA_OUT;
              `OP_ID_A, `OP_ID_B:
                phase_q <= busy_flag ? PH_IGNORE : PH_DATA_OUT;
              default:
                phase_q <= PH_IGNORE;
            endcase
          end
          PH_ADDR:
          begin
            addr_q <= {addr_q[15:0], byte_in};
            addr_cnt_q <= addr_cnt_q + 2'h1;
            if (addr_cnt_q == `ADDR_BYTES - 2'h1)
            begin
              unique case (op_q)
                `OP_READ: phase_q <= PH_DATA_OUT;
                `OP_FAST: phase_q <= PH_DUMMY;
                `OP_PROG: phase_q <= PH_DATA_IN;
                default: phase_q <= PH_IGNORE;
              endcase
            end
          end
          PH_DUMMY:
            phase_q <= PH_DATA_OUT;
          PH_DATA_IN:
          begin
            if (op_q == `OP_WRSR)
            begin
              wsr_data_q <= byte_in;
              phase_q <= PH_IGNORE;
            end
            else if (data_cnt_q != `PAGE_MAX_BYTES)
            begin
              data_cnt_q <= data_cnt_q + 9'h001;
              wsr_data_q <= byte_in;
            end
          end
          PH_DATA_OUT:
            if (op_q == `OP_READ || op_q == `OP_FAST)
              addr_q <= addr_q + 24'h000001;
          PH_IGNORE:
            phase_q <= PH_IGNORE;
          default:
            phase_q <= PH_IGNORE;
        endcase
      end
      if (phase_q == PH_DATA_OUT && clk_fall && id_cnt_q != `ID_BITS)
        id_cnt_q <= id_cnt_q + 5'h01;
    end
  end

  // Output shifter, changes on falling serial clock edges.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q <= 8'h00;
      serial_out_pin <= 1'b0;
      serial_out_oe_n <= 1'b1;
    end
    else if (!selected || phase_q != PH_DATA_OUT)
    begin
      serial_out_oe_n <= 1'b1;
      serial_out_pin <= 1'b0;
    end
    else if (clk_fall)
    begin
      serial_out_oe_n <= 1'b0;
      if (op_q == `OP_ID_A || op_q == `OP_ID_B)
      begin
        if (id_cnt_q == `ID_BITS)
          serial_out_oe_n <= 1'b1;
        else
          serial_out_pin <= id_word[`ID_BITS - 5'h01 - id_cnt_q];
      end
      else if (bit_q == 3'h0)
      begin
        if (op_q == `OP_RDSR)
        begin
          serial_out_pin <= status_byte[7];
          out_q <= {status_byte[6:0], 1'b0};
        end
        else
        begin
          serial_out_pin <= array_rd_data[7];
          out_q <= {array_rd_data[6:0], 1'b0};
        end
      end
      else
      begin
        serial_out_pin <= out_q[7];
        out_q <= {out_q[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      array_rd_addr <= 24'h000000;
    else
      array_rd_addr <= addr_q;
  end

  // Marks that exactly one status data byte has followed the opcode.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wsr_q <= 1'b0;
    else if (!selected)
      wsr_q <= 1'b0;
    else if (byte_done)
      wsr_q <= (phase_q == PH_DATA_IN) && (op_q == `OP_WRSR);
  end

  // Write latch and job launch on clean deselect.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      write_latch_flag <= 1'b0;
      job_valid <= 1'b0;
      job <= '0;
      protect_range_bits <= 3'h0;
      status_lock_bit <= 1'b0;
    end
    else
    begin
      job_valid <= 1'b0;
      if (job_valid)
        write_latch_flag <= 1'b0;
      if (sel_rise && bit_q == 3'h0 && is_write_op)
      begin
        unique case (op_q)
          `OP_WREN:
            if (phase_q == PH_IGNORE && !busy_flag)
              write_latch_flag <= 1'b1;
          `OP_WRDI:
            if (phase_q == PH_IGNORE && !busy_flag)
              write_latch_flag <= 1'b0;
          `OP_WRSR:
            if (write_latch_flag && !busy_flag && wsr_q && !status_lock_bit)
            begin
              protect_range_bits <= wsr_data_q[`ST_PROT_LSB +: 3];
              status_lock_bit <= wsr_data_q[`ST_LOCK];
              job_valid <= 1'b1;
              job.kind <= JOB_STATUS_WRITE;
            end
          `OP_PROG:
            if (write_latch_flag && phase_q == PH_DATA_IN
              && data_cnt_q != 9'h000)
            begin
              job_valid <= 1'b1;
              job.kind <= JOB_PROGRAM;
              job.count <= data_cnt_q;
            end
          `OP_SERASE:
            if (write_latch_flag && phase_q == PH_IGNORE
              && addr_cnt_q == `ADDR_BYTES)
            begin
              job_valid <= 1'b1;
              job.kind <= JOB_SECTOR_ERASE;
            end
          `OP_BERASE:
            if (write_latch_flag && phase_q == PH_IGNORE && !busy_flag)
            begin
              job_valid <= 1'b1;
              job.kind <= JOB_BULK_ERASE;
            end
          default:
            job_valid <= 1'b0;
        endcase
        job.addr <= addr_q;
        job.sector <= addr_q[23:`SECTOR_LSB];
        job.page <= addr_q[23:`PAGE_LSB];
        job.data <= wsr_data_q;
      end
    end
  end
endmodule // flash_cmd_frontend

/* test/flash_fe_sva.sv */
// Port assertions for the serial flash command front end.
`timescale 1ns/10ps
module flash_fe_sva
  import flash_fe_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic select_n_pin,
  input wire logic engine_busy,
  input wire logic serial_out_oe_n,
  input wire logic job_valid,
  input wire job_s job,
  input wire logic write_latch_flag
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // The select line has stayed high for eight core cycles.
  sequence s_idle;
    select_n_pin [*8];
  endsequence
  // A job strobe lasts one cycle and takes the latch down with it.
  sequence s_launch;
    write_latch_flag ##1 (!job_valid && !write_latch_flag);
  endsequence
  property p_launch;
    job_valid |-> s_launch;
  endproperty
  a_launch: assert property (p_launch) else $error("bad job launch");
  property p_busy;
    engine_busy [*3] |-> !job_valid;
  endproperty
  a_busy: assert property (p_busy) else $error("job while busy");
  property p_deselect;
    job_valid |-> $past(select_n_pin, 2);
  endproperty
  a_deselect: assert property (p_deselect) else $error("job in frame");
  property p_sector;
    job_valid |-> job.sector == job.addr[23:18];
  endproperty
  a_sector: assert property (p_sector) else $error("bad sector");
  property p_page;
    job_valid |-> job.page == job.addr[23:8];
  endproperty
  a_page: assert property (p_page) else $error("bad page");
  property p_count;
    job_valid && job.kind == JOB_PROGRAM |-> job.count inside {[1:256]};
  endproperty
  a_count: assert property (p_count) else $error("bad count");
  property p_quiet;
    s_idle |-> serial_out_oe_n;
  endproperty
  a_quiet: assert property (p_quiet) else $error("output on idle");
  property p_latch_set;
    $rose(write_latch_flag) |-> $past(select_n_pin, 2);
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("early latch");
endmodule // flash_fe_sva
bind flash_cmd_frontend flash_fe_sva u_sva (.core_clk(core_clk),
  .rst_n(rst_n), .select_n_pin(select_n_pin), .engine_busy(engine_busy),
  .serial_out_oe_n(serial_out_oe_n), .job_valid(job_valid), .job(job),
  .write_latch_flag(write_latch_flag));

/* test/spi_master_model.sv */
// Bus master model driving the select, clock and data pins.
`timescale 1ns/10ps
module spi_master_model
(
  output logic select_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso,
  output logic rx_valid,
  output logic [7:0] rx_byte
);
  initial
  begin
    select_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    rx_valid = 1'b0;
    rx_byte = 8'h00;
  end
  task automatic open_frame();
    select_n = 1'b0;
    #100;
  endtask
  // The clock stands low and the data line changes once deselected.
  task automatic close_frame();
    #100;
    select_n = 1'b1;
    mosi = ~mosi;
    #400;
  endtask
  task automatic shift(input logic [7:0] b, input int n, input bit chk);
    for (int i = 7; i > 7 - n; i--)
    begin
      mosi = b[i];
      #62;
      rx_byte = {rx_byte[6:0], miso};
      sclk = 1'b1;
      #63;
      sclk = 1'b0;
    end
    if (chk)
    begin
      rx_valid = 1'b1;
      #1;
      rx_valid = 1'b0;
    end
  endtask
endmodule // spi_master_model

/* test/tb_flash_cmd_frontend.sv */
// Self-checking bench for the serial flash command front end.
`timescale 1ns/10ps
`include "flash_fe_defines.svh"
module tb_flash_cmd_frontend import flash_fe_pkg::*;;
  localparam logic [7:0] MAKER = 8'h3A; // Arbitrary value.
  localparam logic [7:0] KIND = 8'h51; // Arbitrary value.
  localparam logic [7:0] SIZE = 8'h6E; // Arbitrary value.
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic engine_busy = 1'b0;
  logic select_n, sclk, mosi, miso, dout, oe_n, job_valid, latch, lock, rx_v;
  logic [7:0] rx_byte, d, rd_data;
  logic [23:0] rd_addr;
  logic [2:0] prot;
  logic [31:0] a;
  logic [31:0] rng = 32'h46;
  job_s job, ej;
  int busy_cnt = 0;
  logic kick = 1'b0;
  int num_errors = 0;
  int n_compared = 0;
  logic [7:0] exp_b[$];
  job_s exp_j[$];
  always #5 core_clk = ~core_clk;
  flash_cmd_frontend #(.MAKER_CODE(MAKER), .TYPE_CODE(KIND),
    .SIZE_CODE(SIZE)) DUT (.core_clk(core_clk), .rst_n(rst_n),
    .select_n_pin(select_n), .sclk_pin(sclk), .serial_in_pin(mosi),
    .serial_out_pin(dout), .serial_out_oe_n(oe_n),
    .engine_busy(engine_busy), .array_rd_data(rd_data),
    .array_rd_addr(rd_addr), .job_valid(job_valid), .job(job),
    .write_latch_flag(latch), .protect_range_bits(prot),
    .status_lock_bit(lock));
  spi_master_model u_master (.select_n(select_n), .sclk(sclk), .mosi(mosi),
    .miso(miso), .rx_valid(rx_v), .rx_byte(rx_byte));
  assign miso = oe_n ? ~dout : dout;
  assign rd_data = mem(rd_addr);
  function automatic logic [7:0] mem(input logic [23:0] x);
    return x[7:0] ^ x[23:16] ^ 8'h5C;
  endfunction
  function automatic logic [31:0] nxt();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic job_s mk(job_e k, logic [23:0] x, logic [8:0] c);
    return '{k, x, x[23:18], x[23:8], c, d};
  endfunction
  task automatic conclude();
    if (num_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Stand-in engine: busy for a while after each job hand-off.
  always @(posedge core_clk)
  begin
    if (job_valid === 1'b1 || kick)
      busy_cnt <= 1000;
    else if (busy_cnt > 0)
      busy_cnt <= busy_cnt - 1;
    engine_busy <= busy_cnt != 0;
  end
  always @(posedge rx_v)
    check(rx_byte, exp_b.size() ? exp_b.pop_front() : 8'hXX);
  always @(posedge core_clk)
    if (job_valid === 1'b1)
    begin
      ej = exp_j.size() ? exp_j.pop_front() : 'x;
      check(job.kind, ej.kind);
      if (ej.kind inside {JOB_PROGRAM, JOB_SECTOR_ERASE})
      begin
        check(job.addr, ej.addr);
        check(job.sector, ej.sector);
        check(job.page, ej.page);
      end
      if (ej.kind == JOB_PROGRAM)
        check(job.count, ej.count);
      if (ej.kind inside {JOB_PROGRAM, JOB_STATUS_WRITE})
        check(job.data, ej.data);
    end
  task automatic cmd(input logic [7:0] op, input logic [31:0] x, input int n);
    u_master.open_frame();
    u_master.shift(op, 8, 0);
    for (int i = 0; i < n; i++)
      u_master.shift(x[31 - 8 * i -: 8], 8, 0);
  endtask
  task automatic op1(input logic [7:0] op);
    cmd(op, 0, 0);
    u_master.close_frame();
  endtask
  task automatic rd(input logic [7:0] op, input logic [7:0] e[$], input int n);
    for (int i = 0; i < n; i++)
    begin
      exp_b.push_back(e[i]);
      u_master.shift(8'h00, 8, 1);
    end
  endtask
  task automatic status(input logic [7:0] e, input int n);
    cmd(`OP_RDSR, 0, 0);
    rd(0, '{e, e}, n);
    u_master.close_frame();
  endtask
  task automatic idle();
    int k;
    for (k = 0; k < 3000 && engine_busy !== 1'b0; k++)
      @(posedge core_clk);
    if (k == 3000)
    begin
      num_errors++;
      conclude();
    end
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    #100;
    status(8'h00, 1);
    op1(`OP_WREN);
    check(latch, 1'b1);
    status(8'h02, 2);
    op1(`OP_WRDI);
    status(8'h00, 1);
    u_master.open_frame();
    u_master.shift(`OP_WREN, 7, 0);
    u_master.close_frame();
    status(8'h00, 1);
    cmd(`OP_PROG, 0, 3);
    u_master.shift(8'h00, 8, 0);
    u_master.close_frame();
    status(8'h00, 1);
    op1(`OP_WREN);
    @(posedge core_clk);
    kick <= 1'b1;
    @(posedge core_clk);
    kick <= 1'b0;
    a = nxt();
    cmd(`OP_SERASE, a << 8, 3);
    u_master.close_frame();
    status(8'h03, 1);
    idle();
    cmd(`OP_SERASE, a << 8, 3);
    u_master.shift(8'h00, 3, 0);
    u_master.close_frame();
    status(8'h02, 1);
    op1(`OP_SERASE);
    exp_j.push_back(mk(JOB_SECTOR_ERASE, a[23:0], 0));
    cmd(`OP_SERASE, a << 8, 3);
    u_master.close_frame();
    status(8'h01, 1);
    idle();
    op1(`OP_WREN);
    a = nxt();
    cmd(`OP_PROG, a << 8, 3);
    for (int i = 0; i < 256; i++)
    begin
      d = nxt();
      u_master.shift(d, 8, 0);
    end
    exp_j.push_back(mk(JOB_PROGRAM, a[23:0], 9'h100));
    u_master.close_frame();
    idle();
    op1(`OP_WREN);
    cmd(`OP_WRSR, 0, 0);
    d = nxt();
    u_master.shift(d, 8, 0);
    exp_j.push_back(mk(JOB_STATUS_WRITE, 0, 0));
    u_master.close_frame();
    idle();
    check({lock, prot, latch}, {d[7], d[4:2], 1'b0});
    op1(`OP_WREN);
    exp_j.push_back(mk(JOB_BULK_ERASE, 0, 0));
    op1(`OP_BERASE);
    idle();
    cmd(`OP_READ, 32'hFFFFFE00, 3);
    rd(0, '{mem(24'hFFFFFE), mem(24'hFFFFFF), mem(0)}, 3);
    u_master.close_frame();
    a = nxt();
    cmd(`OP_FAST, a << 8, 4);
    rd(0, '{mem(a[23:0]), mem(a[23:0] + 24'h1)}, 2);
    u_master.close_frame();
    cmd(`OP_ID_A, 0, 0);
    rd(0, '{MAKER, KIND, SIZE}, 3);
    u_master.close_frame();
    cmd(`OP_ID_B, 0, 0);
    rd(0, '{MAKER}, 1);
    u_master.shift(8'h00, 3, 0);
    u_master.close_frame();
    status(d & 8'h9C, 1);
    check(exp_j.size() + exp_b.size(), 0);
    conclude();
  end
endmodule // tb_flash_cmd_frontend
